/* hw/sadc_defs.vh */
// register map, field positions, reset values and timing counts
`ifndef SADC_DEFS_VH
`define SADC_DEFS_VH

// register indices; byte address is four times the index
`define SADC_IDX_CTRL_A 10'h06C
`define SADC_IDX_CTRL_B 10'h06D
`define SADC_IDX_RES_HI 10'h06E
`define SADC_IDX_RES_LO 10'h06F

// conv_control_a fields
`define SADC_A_START 0
`define SADC_A_REF 1
`define SADC_A_BUSY 2
`define SADC_A_DONE 3
`define SADC_A_CH_LSB 4
`define SADC_A_CH_MSB 7

// conv_control_b fields
`define SADC_B_DIV_LSB 0
`define SADC_B_DIV_MSB 1
`define SADC_B_MODE 2
`define SADC_B_IE 3
`define SADC_B_TRIG 4
`define SADC_B_SLEN_LSB 5
`define SADC_B_SLEN_MSB 6
`define SADC_B_PREC 7

// reset values
`define SADC_CTRL_A_RST 8'h00
`define SADC_CHAN_RST 4'h0
`define SADC_CTRL_B_RST 8'h00
`define SADC_RES_RST 10'h000

// sampling length in conversion clock periods, by code
`define SADC_SLEN_0 5'h04
`define SADC_SLEN_1 5'h07
`define SADC_SLEN_2 5'h0A
`define SADC_SLEN_3 5'h10

// axi4-lite responses
`define SADC_RESP_OKAY 2'h0
`define SADC_RESP_SLVERR 2'h2

`endif

/* hw/sadc_clkdiv.v */
// free-running conversion clock prescaler, one tick per period
`timescale 1ns/1ns
module sadc_clkdiv (
    // clock and reset
    input wire clk,
    input wire rst,
    input wire ce,
    // divide select
    input wire [1:0] div_sel,
    // one machine-cycle strobe per conversion clock period
    output wire tick
);
    reg [2:0] cnt_q;
    reg [2:0] last;

    always @* begin
        case (div_sel)
            2'b00: last = 3'h0;
            2'b01: last = 3'h1;
            2'b10: last = 3'h3;
            default: last = 3'h7;
        endcase
    end

    assign tick = (cnt_q == last);

    // runs free so the start position inside a period varies
    always @(posedge clk) begin
        if (rst) begin
            cnt_q <= 3'h0;
        end else if (ce) begin
            if (cnt_q >= last) begin
                cnt_q <= 3'h0;
            end else begin
                cnt_q <= cnt_q + 3'h1;
            end
        end
    end
endmodule

/* hw/sadc_edge.v */
// rising edge detector for the trigger clock
`timescale 1ns/1ns
module sadc_edge (
    // clock and reset
    input wire clk,
    input wire rst,
    input wire ce,
    // level in, pulse out
    input wire sig_in,
    output wire rise
);
    reg prev_q;

    assign rise = sig_in & ~prev_q;

    always @(posedge clk) begin
        if (rst) begin
            prev_q <= 1'b0;
        end else if (ce) begin
            prev_q <= sig_in;
        end
    end
endmodule

/* hw/sadc_top.v */
// sar a/d converter sequencer with axi4-lite register access
// Functional notes
// - start bit write begins or restarts conversion
// - trigger mode starts on each trigger rise
// - trigger mode cleared stops edge starts
// - start sets busy, connects selected channel
// - sample then hold until conversion ends
// - resolve msb to lsb, load results
// - after transfer busy clears, done sets
// - results change only at conversion end
// - reset, stop, watch halt, clear busy
// - restart with completion still sets done
// - compare ten periods plus one cycle
// - total is startup, sampling and compare
// - startup jitter up to one period
// - trigger select picks timer pin or none
// - precision bit: zero 10-bit, one 8-bit
// - channel codes 0 to 7 route inputs
// - irq while done and enable set
// - done cleared by zero write or start
// - reference switch on when bit is one
// - clock divide 1, 2, 4 or 8
// - sampling 4, 7, 10 or 16 periods
// - start reads zero, ignored in trigger mode
// - 8-bit result low, upper bits zero
//
// The AXI4-Lite register port and the placing of the registers are this design's own decisions.
`timescale 1ns/1ns
`include "sadc_defs.vh"
module sadc_top (
    // clock, reset, clock enable
    input wire clk,
    input wire rst,
    input wire ce,
    // axi4-lite write address
    input wire [11:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output wire s_axi_awready,
    // axi4-lite write data
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output wire s_axi_wready,
    // axi4-lite write response
    output wire [1:0] s_axi_bresp,
    output wire s_axi_bvalid,
    input wire s_axi_bready,
    // axi4-lite read address
    input wire [11:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output wire s_axi_arready,
    // axi4-lite read data
    output wire [31:0] s_axi_rdata,
    output wire [1:0] s_axi_rresp,
    output wire s_axi_rvalid,
    input wire s_axi_rready,
    // power modes
    input wire stop_mode,
    input wire watch_mode,
    // trigger source
    input wire timer_out_pin,
    // analog front end
    output wire [2:0] chan_sel,
    output wire chan_en,
    output wire sample_en,
    output wire hold_en,
    output wire [9:0] trial_code,
    input wire cmp_in,
    output wire ref_switch_on,
    // status
    output wire conv_busy,
    output wire irq
);
    localparam RES_W = 10;
    localparam [2:0] ST_IDLE = 3'd0;
    localparam [2:0] ST_START = 3'd1;
    localparam [2:0] ST_SYNC = 3'd2;
    localparam [2:0] ST_SAMPLE = 3'd3;
    localparam [2:0] ST_COMP = 3'd4;
    localparam [2:0] ST_XFER = 3'd5;
    localparam [1:0] SEL_A = 2'd0;
    localparam [1:0] SEL_B = 2'd1;
    localparam [1:0] SEL_HI = 2'd2;
    localparam [1:0] SEL_LO = 2'd3;
    localparam [RES_W-1:0] MSB_MASK = 10'h200;

    // {hit, select} for a byte address
    function [2:0] reg_decode;
        input [11:0] a;
        begin
            if (a[11:2] == `SADC_IDX_CTRL_A) begin
                reg_decode = {1'b1, SEL_A};
            end else if (a[11:2] == `SADC_IDX_CTRL_B) begin
                reg_decode = {1'b1, SEL_B};
            end else if (a[11:2] == `SADC_IDX_RES_HI) begin
                reg_decode = {1'b1, SEL_HI};
            end else if (a[11:2] == `SADC_IDX_RES_LO) begin
                reg_decode = {1'b1, SEL_LO};
            end else begin
                reg_decode = 3'b000;
            end
        end
    endfunction

    function [4:0] sample_len;
        input [1:0] code;
        begin
            case (code)
                2'b00: sample_len = `SADC_SLEN_0;
                2'b01: sample_len = `SADC_SLEN_1;
                2'b10: sample_len = `SADC_SLEN_2;
                default: sample_len = `SADC_SLEN_3;
            endcase
        end
    endfunction

    // register state
    reg [3:0] chan_q;
    reg ref_q;
    reg done_q;
    reg [7:0] ctrl_b_q;
    reg [7:0] res_lo_q;
    reg [1:0] res_hi_q;

    // bus state
    reg aw_full_q;
    reg w_full_q;
    reg [11:0] awaddr_q;
    reg [7:0] wdata_q;
    reg wstb_q;
    reg bvalid_q;
    reg [1:0] bresp_q;
    reg rvalid_q;
    reg [31:0] rdata_q;
    reg [1:0] rresp_q;

    // sequencer state
    reg [2:0] state_q;
    reg [4:0] cnt_q;
    reg [RES_W-1:0] sar_q;
    reg [RES_W-1:0] mask_q;

    wire tick;
    wire trig_rise;
    wire [1:0] div_sel = ctrl_b_q[`SADC_B_DIV_MSB:`SADC_B_DIV_LSB];
    wire mode_q = ctrl_b_q[`SADC_B_MODE];
    wire ie_q = ctrl_b_q[`SADC_B_IE];
    wire trig_sel_q = ctrl_b_q[`SADC_B_TRIG];
    wire [1:0] slen_q = ctrl_b_q[`SADC_B_SLEN_MSB:`SADC_B_SLEN_LSB];
    wire prec8_q = ctrl_b_q[`SADC_B_PREC];

    sadc_clkdiv u_div (
        .clk(clk),
        .rst(rst),
        .ce(ce),
        .div_sel(div_sel),
        .tick(tick)
    );

    // with the select bit low there is no trigger source at all
    sadc_edge u_edge (
        .clk(clk),
        .rst(rst),
        .ce(ce),
        .sig_in(trig_sel_q & timer_out_pin),
        .rise(trig_rise)
    );

    // write channel: address and data are taken in either order
    wire [2:0] wr_dec = reg_decode(awaddr_q);
    wire wr_fire = ce & aw_full_q & w_full_q & ~bvalid_q;
    wire wr_a = wr_fire & wstb_q & wr_dec[2] & (wr_dec[1:0] == SEL_A);
    wire wr_b = wr_fire & wstb_q & wr_dec[2] & (wr_dec[1:0] == SEL_B);

    assign s_axi_awready = ce & ~aw_full_q & ~bvalid_q;
    assign s_axi_wready = ce & ~w_full_q & ~bvalid_q;
    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp = bresp_q;

    always @(posedge clk) begin
        if (rst) begin
            aw_full_q <= 1'b0;
            w_full_q <= 1'b0;
            awaddr_q <= 12'h000;
            wdata_q <= 8'h00;
            wstb_q <= 1'b0;
            bvalid_q <= 1'b0;
            bresp_q <= `SADC_RESP_OKAY;
        end else if (ce) begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_full_q <= 1'b1;
                awaddr_q <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_full_q <= 1'b1;
                wdata_q <= s_axi_wdata[7:0];
                wstb_q <= s_axi_wstrb[0];
            end
            if (wr_fire) begin
                aw_full_q <= 1'b0;
                w_full_q <= 1'b0;
                bvalid_q <= 1'b1;
                bresp_q <= wr_dec[2] ? `SADC_RESP_OKAY : `SADC_RESP_SLVERR;
            end else if (bvalid_q && s_axi_bready) begin
                bvalid_q <= 1'b0;
            end
        end
    end

    // start and stop conditions
    wire halt = stop_mode | watch_mode;
    wire sw_start = wr_a & wdata_q[`SADC_A_START] & ~mode_q;
    wire hw_start = mode_q & trig_rise;
    wire start = (sw_start | hw_start) & ~halt;
    wire finish = (state_q == ST_XFER) & ~halt;
    wire done_clr = wr_a & ~wdata_q[`SADC_A_DONE];

    // control registers
    always @(posedge clk) begin
        if (rst) begin
            chan_q <= `SADC_CHAN_RST;
            ref_q <= 1'b0;
            ctrl_b_q <= `SADC_CTRL_B_RST;
        end else if (ce) begin
            if (wr_a) begin
                chan_q <= wdata_q[`SADC_A_CH_MSB:`SADC_A_CH_LSB];
                ref_q <= wdata_q[`SADC_A_REF];
            end
            if (wr_b) begin
                ctrl_b_q <= wdata_q;
            end
        end
    end

    // completion wins over a clear or a restart in the same cycle
    always @(posedge clk) begin
        if (rst) begin
            done_q <= 1'b0;
        end else if (ce) begin
            if (finish) begin
                done_q <= 1'b1;
            end else if (start || done_clr) begin
                done_q <= 1'b0;
            end
        end
    end

    // conversion sequencer
    always @(posedge clk) begin
        if (rst) begin
            state_q <= ST_IDLE;
            cnt_q <= 5'h00;
            sar_q <= `SADC_RES_RST;
            mask_q <= `SADC_RES_RST;
        end else if (ce) begin
            if (halt) begin
                state_q <= ST_IDLE;
                mask_q <= `SADC_RES_RST;
            end else if (start) begin
                // a restart abandons whatever was in progress
                state_q <= ST_START;
                sar_q <= `SADC_RES_RST;
                mask_q <= `SADC_RES_RST;
            end else begin
                case (state_q)
                    ST_START: begin
                        state_q <= ST_SYNC;
                    end
                    ST_SYNC: begin
                        // align to the prescaler, the source of jitter
                        if (tick) begin
                            state_q <= ST_SAMPLE;
                            cnt_q <= sample_len(slen_q);
                        end
                    end
                    ST_SAMPLE: begin
                        if (tick) begin
                            if (cnt_q == 5'h01) begin
                                state_q <= ST_COMP;
                                mask_q <= MSB_MASK;
                            end else begin
                                cnt_q <= cnt_q - 5'h01;
                            end
                        end
                    end
                    ST_COMP: begin
                        if (tick) begin
                            if (cmp_in) begin
                                sar_q <= sar_q | mask_q;
                            end
                            mask_q <= mask_q >> 1;
                            if (mask_q == 10'h001) begin
                                state_q <= ST_XFER;
                            end
                        end
                    end
                    ST_XFER: begin
                        state_q <= ST_IDLE;
                    end
                    default: begin
                        state_q <= ST_IDLE;
                    end
                endcase
            end
        end
    end

    // 8-bit mode keeps the top eight resolved bits
    always @(posedge clk) begin
        if (rst) begin
            res_lo_q <= 8'h00;
            res_hi_q <= 2'h0;
        end else if (ce) begin
            if (finish) begin
                if (prec8_q) begin
                    res_lo_q <= sar_q[9:2];
                    res_hi_q <= 2'h0;
                end else begin
                    res_lo_q <= sar_q[7:0];
                    res_hi_q <= sar_q[9:8];
                end
            end
        end
    end

    // read channel
    wire [2:0] rd_dec = reg_decode(s_axi_araddr);
    reg [7:0] rd_val;

    always @* begin
        case (rd_dec[1:0])
            SEL_A: rd_val = {chan_q, done_q, conv_busy, ref_q, 1'b0};
            SEL_B: rd_val = ctrl_b_q;
            SEL_HI: rd_val = {6'h00, res_hi_q};
            default: rd_val = res_lo_q;
        endcase
    end

    assign s_axi_arready = ce & ~rvalid_q;
    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rdata = rdata_q;
    assign s_axi_rresp = rresp_q;

    always @(posedge clk) begin
        if (rst) begin
            rvalid_q <= 1'b0;
            rdata_q <= 32'h00000000;
            rresp_q <= `SADC_RESP_OKAY;
        end else if (ce) begin
            if (s_axi_arvalid && s_axi_arready) begin
                rvalid_q <= 1'b1;
                if (rd_dec[2]) begin
                    rdata_q <= {24'h000000, rd_val};
                    rresp_q <= `SADC_RESP_OKAY;
                end else begin
                    rdata_q <= 32'h00000000;
                    rresp_q <= `SADC_RESP_SLVERR;
                end
            end else if (rvalid_q && s_axi_rready) begin
                rvalid_q <= 1'b0;
            end
        end
    end

    // analog side; codes 8 to 15 connect no input
    assign conv_busy = (state_q != ST_IDLE);
    assign chan_sel = chan_q[2:0];
    assign chan_en = conv_busy & ~chan_q[3];
    assign sample_en = (state_q == ST_SAMPLE);
    assign hold_en = (state_q == ST_COMP) | (state_q == ST_XFER);
    assign trial_code = sar_q | mask_q;
    assign ref_switch_on = ref_q;
    assign irq = done_q & ie_q;
endmodule

/* tb/sadc_afe_model.sv */
// analog front end model: channel levels, sample-hold, comparator
`timescale 1ns/1ns
module sadc_afe_model (
    // clock
    input wire clk,
    // converter side
    input wire [2:0] chan_sel,
    input wire chan_en,
    input wire sample_en,
    input wire hold_en,
    input wire [9:0] trial_code,
    output logic cmp_in,
    // levels set by the bench, ten bits per channel
    input wire [79:0] levels
);
    logic [9:0] held_q = 10'h000;
    logic junk_q = 1'b0;
    always @(posedge clk) begin
        junk_q <= ~junk_q;
        if (sample_en && chan_en) begin
            held_q <= levels[chan_sel*10 +: 10];
        end
    end
    // outside hold the answer means nothing, so it keeps toggling
    assign cmp_in = hold_en ? (held_q >= trial_code) : junk_q;
endmodule

/* tb/sadc_top_properties.sv */
// port-level checks of the converter sequencer
`timescale 1ns/1ns
module sadc_top_properties (
    // clock and reset
    input wire clk,
    input wire rst,
    // bus and power modes
    input wire s_axi_bvalid,
    input wire stop_mode,
    input wire watch_mode,
    // front end and status
    input wire chan_en,
    input wire sample_en,
    input wire hold_en,
    input wire ref_switch_on,
    input wire conv_busy
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    chk_halt_clears_busy: assert property (
        (stop_mode || watch_mode) |=> !conv_busy)
        else $error("busy after halt");
    chk_busy_end_cause: assert property (
        $fell(conv_busy) |-> $past(hold_en) || $past(stop_mode)
        || $past(watch_mode) || $past(rst)) else $error("early busy end");
    chk_start_phase: assert property (
        $rose(conv_busy) |-> !sample_en && !hold_en)
        else $error("no startup phase");
    chk_sample_min: assert property (
        $rose(sample_en) |-> sample_en[*4] or ##[1:3] !conv_busy
        or ##[1:3] $rose(s_axi_bvalid)) else $error("sampling too short");
    chk_hold_min: assert property (
        $rose(hold_en) |-> hold_en[*8] or ##[1:7] !conv_busy
        or ##[1:7] $rose(s_axi_bvalid)) else $error("compare too short");
    chk_front_busy: assert property (
        (chan_en || sample_en || hold_en) |-> conv_busy)
        else $error("front end active while idle");
    chk_phase_excl: assert property (
        !(sample_en && hold_en)) else $error("sample and hold together");
    chk_ref_write: assert property (
        $changed(ref_switch_on) |-> $rose(s_axi_bvalid))
        else $error("reference switch moved without write");
endmodule
bind sadc_top sadc_top_properties sadc_top_properties_i (
    .clk(clk), .rst(rst), .s_axi_bvalid(s_axi_bvalid),
    .stop_mode(stop_mode), .watch_mode(watch_mode), .chan_en(chan_en),
    .sample_en(sample_en), .hold_en(hold_en),
    .ref_switch_on(ref_switch_on), .conv_busy(conv_busy));

/* tb/sadc_top_test.sv */
// self-checking bench for the converter sequencer
`timescale 1ns/1ns
`include "sadc_defs.vh"
module sadc_top_test;
    localparam [11:0] RA = {`SADC_IDX_CTRL_A, 2'h0};
    localparam [11:0] RB = {`SADC_IDX_CTRL_B, 2'h0};
    localparam [11:0] RH = {`SADC_IDX_RES_HI, 2'h0};
    localparam [11:0] RL = {`SADC_IDX_RES_LO, 2'h0};
    logic clk = 1'b0, rst = 1'b1, awv = 1'b0, wv = 1'b0, arv = 1'b0;
    logic stp = 1'b0, wch = 1'b0, tp = 1'b0, en = 1'b1;
    logic [11:0] awa = 12'h000, ara = 12'h000;
    logic [31:0] wd = 32'h00000000;
    logic [79:0] lv = 80'h0;
    wire awr, wrdy, bv, arr, rv, cen, smp, hld, cmp, refon, busy, irq;
    wire [1:0] br, rr;
    wire [31:0] rdat;
    wire [2:0] csel;
    wire [9:0] trial;
    int fails = 0, n_compared = 0, cyc = 0, bcnt = 0, blen = 0;
    int nt[4] = '{4, 7, 10, 16};
    sadc_top sadc_top_i (
        .clk(clk), .rst(rst), .ce(en),
        .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr),
        .s_axi_wdata(wd), .s_axi_wstrb(4'hF), .s_axi_wvalid(wv),
        .s_axi_wready(wrdy), .s_axi_bresp(br), .s_axi_bvalid(bv),
        .s_axi_bready(1'b1), .s_axi_araddr(ara), .s_axi_arvalid(arv),
        .s_axi_arready(arr), .s_axi_rdata(rdat), .s_axi_rresp(rr),
        .s_axi_rvalid(rv), .s_axi_rready(1'b1), .stop_mode(stp),
        .watch_mode(wch), .timer_out_pin(tp), .chan_sel(csel),
        .chan_en(cen), .sample_en(smp), .hold_en(hld), .trial_code(trial),
        .cmp_in(cmp), .ref_switch_on(refon), .conv_busy(busy), .irq(irq));
    sadc_afe_model sadc_afe_model_i (
        .clk(clk), .chan_sel(csel), .chan_en(cen), .sample_en(smp),
        .hold_en(hld), .trial_code(trial), .cmp_in(cmp), .levels(lv));
    always #4 clk = ~clk;
    task automatic end_sim();
        if (fails == 0 && n_compared > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (busy) begin
            bcnt <= bcnt + 1;
        end else if (bcnt != 0) begin
            blen <= bcnt;
            bcnt <= 0;
        end
        if (cyc == 20000) begin
            fails++;
            end_sim();
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            fails++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    function automatic logic [31:0] rsp(input logic [11:0] a);
        return {30'h0, a[11:4] == 8'h1B ? `SADC_RESP_OKAY
                                        : `SADC_RESP_SLVERR};
    endfunction
    function automatic logic [7:0] expd(input logic [9:0] v,
                                        input logic p, input logic hi);
        if (hi)
            return p ? 8'h00 : {6'h00, v[9:8]};
        return p ? v[9:2] : v[7:0];
    endfunction
    task automatic wr(input logic [11:0] a, input logic [7:0] v);
        awa <= a;
        wd <= {24'h000000, v};
        awv <= 1'b1;
        wv <= 1'b1;
        @(posedge clk);
        while (!bv) begin
            if (awr) awv <= 1'b0;
            if (wrdy) wv <= 1'b0;
            @(posedge clk);
        end
        chk({30'h0, br}, rsp(a));
    endtask
    task automatic rchk(input logic [11:0] a, input logic [7:0] e);
        ara <= a;
        arv <= 1'b1;
        @(posedge clk);
        while (!arr) @(posedge clk);
        arv <= 1'b0;
        @(posedge clk);
        while (!rv) @(posedge clk);
        chk(rdat, {24'h000000, e});
        chk({30'h0, rr}, rsp(a));
    endtask
    task automatic idle();
        @(posedge clk);
        while (busy) @(posedge clk);
        @(posedge clk);
    endtask
    initial begin
        int i, lo;
        logic [9:0] lvl;
        logic [7:0] cb, prev;
        prev = 8'h00;
        lo = $urandom(32'hBAA30706);
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        for (i = 0; i < 4; i++) rchk(RA + 12'(4 * i), 8'h00);
        wr(12'h000, 8'hFF);
        rchk(12'h000, 8'h00);
        for (i = 0; i < 8; i++) begin
            lvl = 10'($urandom);
            lv[i*10 +: 10] <= lvl;
            cb = {1'($urandom), i[2:1], 1'b0, 1'($urandom), 1'b0, i[1:0]};
            wr(RB, cb);
            wr(RA, {i[3:0], 4'b0011});
            chk({31'h0, refon}, 32'h1);
            rchk(RA, {i[3:0], 4'b0110});
            rchk(RL, prev);
            idle();
            lo = (nt[cb[6:5]] + 10) * (1 << cb[1:0]) + 3;
            chk(blen >= lo && blen < lo + (1 << cb[1:0]), 1);
            prev = expd(lvl, cb[7], 1'b0);
            rchk(RL, prev);
            rchk(RH, expd(lvl, cb[7], 1'b1));
            rchk(RA, {i[3:0], 4'b1010});
            chk({31'h0, irq}, {31'h0, cb[3]});
            wr(RA, {i[3:0], 4'b0010});
            chk({31'h0, irq}, 32'h0);
        end
        lv[70 +: 10] <= 10'h155;
        wr(RB, 8'h00);
        wr(RA, 8'h73);
        while (!hld) @(posedge clk);
        lv[70 +: 10] <= 10'h2AA;
        wr(RA, 8'h73);
        idle();
        chk(blen > 17, 1);
        rchk(RL, 8'hAA);
        rchk(RH, 8'h02);
        // six frozen cycles stretch a 17-cycle conversion to 23
        wr(RA, 8'h73);
        repeat (5) @(posedge clk);
        en <= 1'b0;
        repeat (6) @(posedge clk);
        en <= 1'b1;
        idle();
        chk(blen == 23, 1);
        // third pass is a mid-run reset; reference is already off then
        for (i = 0; i < 3; i++) begin
            wr(RA, (i == 2) ? 8'h71 : 8'h73);
            repeat (4) @(posedge clk);
            stp <= (i == 0);
            wch <= (i == 1);
            rst <= (i == 2);
            @(posedge clk);
            stp <= 1'b0;
            wch <= 1'b0;
            rst <= 1'b0;
            repeat (2) @(posedge clk);
            chk({31'h0, busy}, 32'h0);
            rchk(RA, (i == 2) ? 8'h00 : 8'h72);
            rchk(RL, (i == 2) ? 8'h00 : 8'hAA);
        end
        wr(RB, 8'h14);
        tp <= 1'b1;
        repeat (3) @(posedge clk);
        chk({31'h0, busy}, 32'h1);
        idle();
        repeat (4) @(posedge clk);
        chk({31'h0, busy}, 32'h0);
        tp <= 1'b0;
        wr(RA, 8'h73);
        @(posedge clk);
        chk({31'h0, busy}, 32'h0);
        for (i = 0; i < 2; i++) begin
            wr(RB, i ? 8'h04 : 8'h10);
            tp <= 1'b1;
            repeat (3) @(posedge clk);
            chk({31'h0, busy}, 32'h0);
            tp <= 1'b0;
            @(posedge clk);
        end
        end_sim();
    end
endmodule
